/* File: srcc_chk.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Port-level checker for the reset and clock control block
module srcc_chk (
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [6:0]  factory_trim_in,
  input wire logic        cpu_sleep_in,
  input wire logic [15:0] periph_run_en_in,
  input wire logic        pwm_clk_en_out,
  input wire logic [6:0]  osc_trim_out,
  input wire logic        usb_phy_pll_up_out,
  input wire logic [15:0] periph_clk_en_out,
  input wire logic [15:0] periph_rst_out,
  input wire logic        sys_rst_req_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [6:0] gap_reg;
  // Cycles since the last divided clock pulse
  always_ff @(posedge core_clk_in)
    if (!rst_n_in || pwm_clk_en_out) gap_reg <= 7'h00;
    else gap_reg <= gap_reg + 7'h01;
  // Bus and whole-device reset
  chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data not zero outside read slot");
  chk_swreset_req: assert property (reg_wr_in && reg_addr_in == 8'h20 && reg_wdata_in == 32'h1 |=> sys_rst_req_out)
    else $error("software reset not requested");
  chk_swreq_once: assert property (sys_rst_req_out |=> !sys_rst_req_out)
    else $error("software reset request longer than one cycle");
  chk_swreq_cause: assert property (sys_rst_req_out |-> $past(reg_wr_in) && $past(reg_addr_in) == 8'h20)
    else $error("software reset request without a write");
  chk_rst_trim: assert property ($rose(rst_n_in) |-> osc_trim_out == 7'h40)
    else $error("trim not nominal after reset");
  // Peripheral reset, trim, power control, divided clock gap and awake peripheral clocks
  chk_prst_pulse: assert property (reg_wr_in && reg_addr_in == 8'h14 && reg_wdata_in[0]
    |=> periph_rst_out[0] [*4] ##1 !periph_rst_out[0])
    else $error("peripheral reset pulse wrong length");
  chk_trim_user: assert property (reg_wr_in && reg_addr_in == 8'h08 && reg_wdata_in[9:8] == 2'h3
    |=> {25'h0, osc_trim_out} == ($past(reg_wdata_in) & 32'h7F))
    else $error("user trim not applied");
  chk_trim_fact: assert property (reg_wr_in && reg_addr_in == 8'h08 && reg_wdata_in[9:8] == 2'h2
    |=> osc_trim_out == $past(factory_trim_in))
    else $error("factory trim not restored");
  chk_usb_follow: assert property (reg_wr_in && reg_addr_in == 8'h0C
    |=> usb_phy_pll_up_out == |($past(reg_wdata_in) & 32'h2))
    else $error("usb pll power does not follow control");
  chk_pwm_gap: assert property (gap_reg < 7'h40)
    else $error("divided clock gap longer than 64");
  chk_awake_clk: assert property (!cpu_sleep_in |-> periph_clk_en_out == periph_run_en_in)
    else $error("awake peripheral clocks differ from run enables");
endmodule : srcc_chk

bind srcc_top srcc_chk chk_u (.core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .factory_trim_in, .cpu_sleep_in, .periph_run_en_in, .pwm_clk_en_out, .osc_trim_out,
  .usb_phy_pll_up_out, .periph_clk_en_out, .periph_rst_out, .sys_rst_req_out);

/* File: srcc_pkg.sv */
package srcc_pkg;
  typedef enum logic [1:0] {
    SRCC_TRIM_KEEP,
    SRCC_TRIM_AUTO,
    SRCC_TRIM_FACT,
    SRCC_TRIM_USER
  } srcc_trim_cmd_t;

  typedef enum logic [1:0] {
    SRCC_CAL_IDLE,
    SRCC_CAL_RUN
  } srcc_cal_state_t;
endpackage : srcc_pkg

/* File: srcc_regs.svh */
`ifndef SRCC_REGS_SVH
`define SRCC_REGS_SVH

// Register addresses (byte, word aligned)
`define SRCC_ADDR_CAUSE      8'h00
`define SRCC_ADDR_PWMDIV     8'h04
`define SRCC_ADDR_OSCCAL     8'h08
`define SRCC_ADDR_PLLCTL     8'h0C
`define SRCC_ADDR_SLEEPCFG   8'h10
`define SRCC_ADDR_PERIPH_RST 8'h14
`define SRCC_ADDR_IRQ_STAT   8'h18
`define SRCC_ADDR_IRQ_MASK   8'h1C
`define SRCC_ADDR_SWRESET    8'h20
`define SRCC_ADDR_CLKGATE    8'h24

// Reset cause bit positions
`define SRCC_CAUSE_EXT  0
`define SRCC_CAUSE_POR  1
`define SRCC_CAUSE_BOR  2
`define SRCC_CAUSE_WDOG 3
`define SRCC_CAUSE_SW   4
`define SRCC_CAUSE_REG  5
`define SRCC_CAUSE_W    6

// PWM divider selections 0..6 mean divide by 2**sel
`define SRCC_PWMDIV_W    3
`define SRCC_PWMDIV_MAX  3'h6
`define SRCC_PWMDIV_RST  3'h0
`define SRCC_PWMCNT_W    6

// Oscillator trim
`define SRCC_TRIM_W       7
`define SRCC_TRIM_NOMINAL 7'h40
`define SRCC_OSCCMD_LSB   8
`define SRCC_OSCCMD_MSB   9

// PLL control bits
`define SRCC_PLL_VERIFY_BIT 0
`define SRCC_USBPLL_UP_BIT  1

// Interrupt status bits
`define SRCC_IRQ_PLL_LOSS 0
`define SRCC_IRQ_CAL_DONE 1
`define SRCC_IRQ_W        2

// Peripheral count and pulse length
`define SRCC_NPERIPH     16
`define SRCC_PRST_CYCLES 4'h4
`define SRCC_PRST_W      4

// PLL loss window in clock cycles of the reference
`define SRCC_PLL_WIN_W   8
`define SRCC_PLL_WIN     8'hFF

// Software reset request key
`define SRCC_SWRESET_KEY 32'h0000_0001

`endif

/* File: srcc_tb.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module tb;
  logic        core_clk_in, rst_n_in, reg_wr_in, reg_rd_in, tick_on, pll_on;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, d, e, m;
  logic        cause_ext_in, cause_por_in, cause_bor_in, cause_wdog_in, cause_reg_in;
  logic [6:0]  factory_trim_in, osc_trim_out;
  logic        hib_present_in, hib_enabled_in, hib_rtc_running_in, hib_tick_in, osc_fast_in;
  logic        main_osc_tick_in, pll_tick_in, cpu_sleep_in;
  logic [15:0] periph_run_en_in, periph_clk_en_out, periph_wake_en_out, periph_rst_out;
  logic        pwm_clk_en_out, usb_phy_pll_up_out, sys_rst_req_out, irq_out;
  logic [7:0]  adr [8] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h24, 8'h30};
  int          miscompares, n_checks, seed, i, p, r;

  srcc_top dut_u (.core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .cause_ext_in, .cause_por_in, .cause_bor_in, .cause_wdog_in, .cause_reg_in, .factory_trim_in,
    .hib_present_in, .hib_enabled_in, .hib_rtc_running_in, .hib_tick_in, .osc_fast_in, .main_osc_tick_in,
    .pll_tick_in, .cpu_sleep_in, .periph_run_en_in, .pwm_clk_en_out, .osc_trim_out, .usb_phy_pll_up_out,
    .periph_clk_en_out, .periph_wake_en_out, .periph_rst_out, .sys_rst_req_out, .irq_out);

  // Clock and reference tick sources
  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in)
  begin
    main_osc_tick_in <= tick_on & ~main_osc_tick_in;
    pll_tick_in      <= pll_on & ~pll_tick_in;
  end

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= v;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1; reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask : rd

  // One-cycle pulse on the cause inputs {reg, wdog, bor, por, ext}
  task cause(input logic [4:0] c);
    @(posedge core_clk_in);
    {cause_reg_in, cause_wdog_in, cause_bor_in, cause_por_in, cause_ext_in} <= c;
    @(posedge core_clk_in);
    {cause_reg_in, cause_wdog_in, cause_bor_in, cause_por_in, cause_ext_in} <= 5'h00;
  endtask : cause

  task hib_ticks(input int n);
    repeat (n)
    begin
      @(posedge core_clk_in); hib_tick_in <= 1'b1;
      @(posedge core_clk_in); hib_tick_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
    end
  endtask : hib_ticks

  // Cycles from one divided clock pulse to the next
  task pwm_gap(output int n);
    int k;
    k = 0;
    #1 while (pwm_clk_en_out !== 1'b1 && k < 200) begin @(posedge core_clk_in); #1 k++; end
    n = 0;
    do begin @(posedge core_clk_in); #1 n++; end while (pwm_clk_en_out !== 1'b1 && n < 200);
    if (n >= 200 || k >= 200) begin miscompares++; final_report; end
  endtask : pwm_gap

  initial
  begin
    seed = 33; miscompares = 0; n_checks = 0; core_clk_in = 1'b0; rst_n_in = 1'b0;
    reg_wr_in = 1'b0; reg_rd_in = 1'b0; reg_addr_in = 8'h00; reg_wdata_in = 32'h0;
    {cause_reg_in, cause_wdog_in, cause_bor_in, cause_por_in, cause_ext_in} = 5'h00;
    factory_trim_in = 7'($random(seed)) & 7'h3F; hib_present_in = 1'b0; hib_enabled_in = 1'b1;
    hib_rtc_running_in = 1'b1; hib_tick_in = 1'b0; osc_fast_in = 1'b1; main_osc_tick_in = 1'b0;
    pll_tick_in = 1'b0; tick_on = 1'b0; pll_on = 1'b0; cpu_sleep_in = 1'b0; periph_run_en_in = 16'h0;
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    // Reset values and an unmapped address
    for (i = 0; i < 8; i++) begin rd(adr[i], d); chk(d, 32'h0); end
    rd(8'h08, d); chk(d & 32'h7F, 32'h40);
    $display("test defaults done");
    // Sticky causes accumulate, partial write-one clear, external clears
    e = 32'h0;
    for (i = 1; i < 5; i++)
    begin
      cause(5'(1 << i));
      e = e | ((i == 4) ? 32'h20 : (32'h1 << i));
      rd(8'h00, d); chk(d, e);
    end
    m = $random(seed) & 32'h2E; wr(8'h00, m); e = e & ~m;
    rd(8'h00, d); chk(d, e);
    wr(8'h00, 32'h0); rd(8'h00, d); chk(d, e);
    cause(5'h01); rd(8'h00, d); chk(d, 32'h1);
    $display("test causes done");
    // Every divider ratio, started at a random one
    r = {$random(seed)} % 7;
    for (i = 0; i < 7; i++)
    begin
      p = (i + r) % 7;
      wr(8'h04, 32'(p)); rd(8'h04, d); chk(d, 32'(p));
      pwm_gap(p); pwm_gap(p); chk(32'(p), 32'h1 << ((i + r) % 7));
    end
    wr(8'h04, 32'h7); rd(8'h04, d); chk(d, 32'((r + 6) % 7));
    $display("test divider done");
    // User, factory and automatic trim
    m = $random(seed) & 32'h7F; wr(8'h08, 32'h300 | m);
    rd(8'h08, d); chk(d & 32'h7F, m);
    wr(8'h08, 32'h200); #1 chk({25'h0, osc_trim_out}, {25'h0, factory_trim_in});
    wr(8'h08, 32'h100); hib_ticks(3); rd(8'h08, d); chk(d & 32'h7F, {25'h0, factory_trim_in});
    wr(8'h18, 32'h3); hib_present_in <= 1'b1;
    wr(8'h08, 32'h100); hib_ticks(3); rd(8'h08, d); chk(d & 32'h7F, {25'h0, factory_trim_in} + 32'h3);
    hib_enabled_in <= 1'b0; repeat (4) @(posedge core_clk_in);
    rd(8'h18, d); chk(d, 32'h2);
    wr(8'h18, 32'h2); rd(8'h18, d); chk(d, 32'h0);
    $display("test trim done");
    // PLL verification with running and stopped PLL, mask and clear
    tick_on <= 1'b1; pll_on <= 1'b1;
    wr(8'h1C, 32'h1); wr(8'h0C, 32'h3);
    #1 chk({31'h0, usb_phy_pll_up_out}, 32'h1);
    repeat (1100) @(posedge core_clk_in);
    #1 chk({31'h0, irq_out}, 32'h0);
    pll_on <= 1'b0;
    for (i = 0; i < 1500 && irq_out !== 1'b1; i++) begin @(posedge core_clk_in); #1; end
    if (i >= 1500) begin miscompares++; final_report; end
    rd(8'h18, d); chk(d & 32'h1, 32'h1);
    wr(8'h1C, 32'h0); #1 chk({31'h0, irq_out}, 32'h0);
    wr(8'h0C, 32'h2); wr(8'h18, 32'h1); rd(8'h18, d); chk(d, 32'h0);
    wr(8'h0C, 32'h0); #1 chk({31'h0, usb_phy_pll_up_out}, 32'h0);
    tick_on <= 1'b0;
    $display("test pll done");
    // Sleep clocking with gating on and off
    for (i = 0; i < 8; i++)
    begin
      m = $random(seed) & 32'hFFFF; wr(8'h10, m); wr(8'h24, 32'(i & 1));
      periph_run_en_in <= 16'($random(seed)); cpu_sleep_in <= i[1];
      @(posedge core_clk_in);
      #1 chk({16'h0, periph_clk_en_out}, {16'h0, periph_run_en_in} & ((i % 4 == 3) ? m : 32'hFFFF));
      chk({16'h0, periph_wake_en_out}, {16'h0, periph_run_en_in} & ((i % 2 == 1) ? m : 32'hFFFF));
    end
    cpu_sleep_in <= 1'b0;
    $display("test sleep done");
    // Individual peripheral reset pulse
    m = ($random(seed) & 32'hFFFF) | 32'h1; wr(8'h14, m);
    #1 chk({16'h0, periph_rst_out}, m);
    repeat (4) @(posedge core_clk_in);
    #1 chk({16'h0, periph_rst_out}, 32'h0);
    $display("test periph reset done");
    // Whole-device reset keeps causes and adds the software bit
    wr(8'h00, 32'h3F);
    cause(5'h02); wr(8'h04, 32'h3); wr(8'h08, 32'h305);
    wr(8'h20, 32'h2); rd(8'h04, d); chk(d, 32'h3);
    wr(8'h20, 32'h1); #1 chk({31'h0, sys_rst_req_out}, 32'h1);
    repeat (6) @(posedge core_clk_in);
    rd(8'h00, d); chk(d, 32'h12);
    rd(8'h04, d); chk(d, 32'h0);
    rd(8'h08, d); chk(d & 32'h7F, 32'h40);
    $display("test software reset done");
    final_report;
  end
endmodule : tb

/* File: srcc_top.sv */
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "srcc_regs.svh"
module srcc_top
  import srcc_pkg::*;
(
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic [7:0]                 reg_addr_in,
  input  wire logic [31:0]                reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic      [31:0]                reg_rdata_out,
  input  wire logic                       cause_ext_in,
  input  wire logic                       cause_por_in,
  input  wire logic                       cause_bor_in,
  input  wire logic                       cause_wdog_in,
  input  wire logic                       cause_reg_in,
  input  wire logic [`SRCC_TRIM_W-1:0]    factory_trim_in,
  input  wire logic                       hib_present_in,
  input  wire logic                       hib_enabled_in,
  input  wire logic                       hib_rtc_running_in,
  input  wire logic                       hib_tick_in,
  input  wire logic                       osc_fast_in,
  input  wire logic                       main_osc_tick_in,
  input  wire logic                       pll_tick_in,
  input  wire logic                       cpu_sleep_in,
  input  wire logic [`SRCC_NPERIPH-1:0]   periph_run_en_in,
  output logic                            pwm_clk_en_out,
  output logic [`SRCC_TRIM_W-1:0]         osc_trim_out,
  output logic                            usb_phy_pll_up_out,
  output logic [`SRCC_NPERIPH-1:0]        periph_clk_en_out,
  output logic [`SRCC_NPERIPH-1:0]        periph_wake_en_out,
  output logic [`SRCC_NPERIPH-1:0]        periph_rst_out,
  output logic                            sys_rst_req_out,
  output logic                            irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [`SRCC_CAUSE_W-1:0]   cause_reg;
  logic [`SRCC_CAUSE_W-1:0]   cause_next;
  logic                       sw_rst_reg;
  logic [`SRCC_PWMDIV_W-1:0]  pwmdiv_reg;
  logic [`SRCC_PWMDIV_W-1:0]  pwmdiv_act_reg;
  logic [`SRCC_PWMCNT_W-1:0]  pwmcnt_reg;
  logic [`SRCC_PWMCNT_W-1:0]  pwm_limit;
  logic                       pwm_wrap;
  logic [`SRCC_TRIM_W-1:0]    trim_reg;
  srcc_trim_cmd_t             trim_cmd;
  srcc_cal_state_t            cal_state_reg;
  logic                       cal_allowed;
  logic                       pll_verify_reg;
  logic                       usbpll_reg;
  logic [`SRCC_PLL_WIN_W-1:0] pll_win_reg;
  logic                       pll_seen_reg;
  logic                       pll_loss;
  logic                       cal_done;
  logic                       gate_en_reg;
  logic [`SRCC_NPERIPH-1:0]   sleep_sel_reg;
  logic [`SRCC_IRQ_W-1:0]     irq_stat_reg;
  logic [`SRCC_IRQ_W-1:0]     irq_mask_reg;
  logic [`SRCC_IRQ_W-1:0]     irq_set;
  logic [`SRCC_IRQ_W-1:0]     irq_clr;
  logic [31:0]                rdata_mux;
  logic                       wr_cause;
  logic                       wr_pwmdiv;
  logic                       wr_osccal;
  logic                       wr_pllctl;
  logic                       wr_sleep;
  logic                       wr_prst;
  logic                       wr_stat;
  logic                       wr_mask;
  logic                       wr_swrst;
  logic                       wr_gate;
  logic                       soft_rst;
  logic [`SRCC_CAUSE_W-1:0]   hw_cause;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_cause  = reg_wr_in && (reg_addr_in == `SRCC_ADDR_CAUSE);
  assign wr_pwmdiv = reg_wr_in && (reg_addr_in == `SRCC_ADDR_PWMDIV);
  assign wr_osccal = reg_wr_in && (reg_addr_in == `SRCC_ADDR_OSCCAL);
  assign wr_pllctl = reg_wr_in && (reg_addr_in == `SRCC_ADDR_PLLCTL);
  assign wr_sleep  = reg_wr_in && (reg_addr_in == `SRCC_ADDR_SLEEPCFG);
  assign wr_prst   = reg_wr_in && (reg_addr_in == `SRCC_ADDR_PERIPH_RST);
  assign wr_stat   = reg_wr_in && (reg_addr_in == `SRCC_ADDR_IRQ_STAT);
  assign wr_mask   = reg_wr_in && (reg_addr_in == `SRCC_ADDR_IRQ_MASK);
  assign wr_gate   = reg_wr_in && (reg_addr_in == `SRCC_ADDR_CLKGATE);
  assign wr_swrst  = reg_wr_in && (reg_addr_in == `SRCC_ADDR_SWRESET)
                     && (reg_wdata_in == `SRCC_SWRESET_KEY);

  // Soft reset of all but the cause record and read data, one cycle after request
  assign soft_rst        = sw_rst_reg;
  assign sys_rst_req_out = sw_rst_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause record
  assign hw_cause[`SRCC_CAUSE_EXT]  = cause_ext_in;
  assign hw_cause[`SRCC_CAUSE_POR]  = cause_por_in;
  assign hw_cause[`SRCC_CAUSE_BOR]  = cause_bor_in;
  assign hw_cause[`SRCC_CAUSE_WDOG] = cause_wdog_in;
  assign hw_cause[`SRCC_CAUSE_SW]   = sw_rst_reg;
  assign hw_cause[`SRCC_CAUSE_REG]  = cause_reg_in;

  // External reset wipes older causes; sets win over clears
  assign cause_next = cause_ext_in
                      ? hw_cause
                      : ((cause_reg & ~({`SRCC_CAUSE_W{wr_cause}}
                         & reg_wdata_in[`SRCC_CAUSE_W-1:0])) | hw_cause);

  // Cause record ignores the soft reset so it survives it
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      cause_reg <= '0;
    else
      cause_reg <= cause_next;
  end

  // Software reset request pulse
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || soft_rst)
      sw_rst_reg <= 1'b0;
    else
      sw_rst_reg <= wr_swrst;
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM clock divider
  assign pwm_limit = `SRCC_PWMCNT_W'((7'h01 << pwmdiv_act_reg) - 7'h01);
  assign pwm_wrap  = (pwmcnt_reg == pwm_limit);
  assign pwm_clk_en_out = pwm_wrap;

  // Selection register and boundary-aligned active copy
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || soft_rst)
    begin
      pwmdiv_reg     <= `SRCC_PWMDIV_RST;
      pwmdiv_act_reg <= `SRCC_PWMDIV_RST;
      pwmcnt_reg     <= '0;
    end
    else
    begin
      if (wr_pwmdiv && reg_wdata_in[`SRCC_PWMDIV_W-1:0] <= `SRCC_PWMDIV_MAX)
        pwmdiv_reg <= reg_wdata_in[`SRCC_PWMDIV_W-1:0];
      if (pwm_wrap)
      begin
        pwmcnt_reg     <= '0;
        pwmdiv_act_reg <= pwmdiv_reg;
      end
      else
        pwmcnt_reg <= pwmcnt_reg + `SRCC_PWMCNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator trim
  assign trim_cmd    = srcc_trim_cmd_t'(reg_wdata_in[`SRCC_OSCCMD_MSB:`SRCC_OSCCMD_LSB]);
  assign cal_allowed = hib_present_in && hib_enabled_in && hib_rtc_running_in;
  assign osc_trim_out = trim_reg;
  assign cal_done    = (cal_state_reg == SRCC_CAL_RUN) && !cal_allowed;

  // Trim register and automatic calibration stepping
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || soft_rst)
    begin
      trim_reg      <= `SRCC_TRIM_NOMINAL;
      cal_state_reg <= SRCC_CAL_IDLE;
    end
    else if (wr_osccal)
    begin
      case (trim_cmd)
        SRCC_TRIM_USER:
        begin
          trim_reg      <= reg_wdata_in[`SRCC_TRIM_W-1:0];
          cal_state_reg <= SRCC_CAL_IDLE;
        end
        SRCC_TRIM_FACT:
        begin
          trim_reg      <= factory_trim_in;
          cal_state_reg <= SRCC_CAL_IDLE;
        end
        SRCC_TRIM_AUTO:
          cal_state_reg <= cal_allowed ? SRCC_CAL_RUN : SRCC_CAL_IDLE;
        default:
          cal_state_reg <= cal_state_reg;
      endcase
    end
    else
    begin
      case (cal_state_reg)
        SRCC_CAL_RUN:
        begin
          if (!cal_allowed)
            cal_state_reg <= SRCC_CAL_IDLE;
          else if (hib_tick_in && osc_fast_in && trim_reg != {`SRCC_TRIM_W{1'b1}})
            trim_reg <= trim_reg + `SRCC_TRIM_W'(1);
          else if (hib_tick_in && !osc_fast_in && trim_reg != '0)
            trim_reg <= trim_reg - `SRCC_TRIM_W'(1);
        end
        default:
          cal_state_reg <= SRCC_CAL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL verification timer and USB PLL power
  assign pll_loss = pll_verify_reg && main_osc_tick_in
                    && (pll_win_reg == `SRCC_PLL_WIN) && !pll_seen_reg;
  assign usb_phy_pll_up_out = usbpll_reg;

  // Window of reference ticks; PLL tick must appear in each window
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || soft_rst || !pll_verify_reg)
    begin
      pll_win_reg  <= '0;
      pll_seen_reg <= 1'b0;
    end
    else if (main_osc_tick_in && pll_win_reg == `SRCC_PLL_WIN)
    begin
      pll_win_reg  <= '0;
      pll_seen_reg <= pll_tick_in;
    end
    else
    begin
      if (main_osc_tick_in)
        pll_win_reg <= pll_win_reg + `SRCC_PLL_WIN_W'(1);
      if (pll_tick_in)
        pll_seen_reg <= 1'b1;
    end
  end

  // PLL control register
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || soft_rst)
    begin
      pll_verify_reg <= 1'b0;
      usbpll_reg     <= 1'b0;
    end
    else if (wr_pllctl)
    begin
      pll_verify_reg <= reg_wdata_in[`SRCC_PLL_VERIFY_BIT];
      usbpll_reg     <= reg_wdata_in[`SRCC_USBPLL_UP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep clock gating
  assign periph_clk_en_out  = (cpu_sleep_in && gate_en_reg)
                              ? (periph_run_en_in & sleep_sel_reg)
                              : periph_run_en_in;
  assign periph_wake_en_out = gate_en_reg ? (periph_run_en_in & sleep_sel_reg)
                                          : periph_run_en_in;

  // Gating enable and sleep selection
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || soft_rst)
    begin
      gate_en_reg   <= 1'b0;
      sleep_sel_reg <= '0;
    end
    else
    begin
      if (wr_gate)
        gate_en_reg <= reg_wdata_in[0];
      if (wr_sleep)
        sleep_sel_reg <= reg_wdata_in[`SRCC_NPERIPH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-peripheral reset pulse stretchers
  genvar gi;
  generate
    for (gi = 0; gi < `SRCC_NPERIPH; gi++)
    begin : g_prst
      logic [`SRCC_PRST_W-1:0] cnt_reg;
      always_ff @(posedge core_clk_in)
      begin
        if (!rst_n_in)
          cnt_reg <= '0;
        else if (soft_rst || (wr_prst && reg_wdata_in[gi]))
          cnt_reg <= `SRCC_PRST_CYCLES;
        else if (cnt_reg != '0)
          cnt_reg <= cnt_reg - `SRCC_PRST_W'(1);
      end
      assign periph_rst_out[gi] = (cnt_reg != '0);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask
  assign irq_set[`SRCC_IRQ_PLL_LOSS] = pll_loss;
  assign irq_set[`SRCC_IRQ_CAL_DONE] = cal_done;
  assign irq_clr = {`SRCC_IRQ_W{wr_stat}} & reg_wdata_in[`SRCC_IRQ_W-1:0];
  assign irq_out = |(irq_stat_reg & irq_mask_reg);

  // Sticky status, set wins over clear
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || soft_rst)
    begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end
    else
    begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (wr_mask)
        irq_mask_reg <= reg_wdata_in[`SRCC_IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb
  begin
    rdata_mux = '0;
    case (reg_addr_in)
      `SRCC_ADDR_CAUSE:    rdata_mux[`SRCC_CAUSE_W-1:0]  = cause_reg;
      `SRCC_ADDR_PWMDIV:   rdata_mux[`SRCC_PWMDIV_W-1:0] = pwmdiv_reg;
      `SRCC_ADDR_OSCCAL:
      begin
        rdata_mux[`SRCC_TRIM_W-1:0]  = trim_reg;
        rdata_mux[`SRCC_OSCCMD_LSB]  = (cal_state_reg == SRCC_CAL_RUN);
      end
      `SRCC_ADDR_PLLCTL:
      begin
        rdata_mux[`SRCC_PLL_VERIFY_BIT] = pll_verify_reg;
        rdata_mux[`SRCC_USBPLL_UP_BIT]  = usbpll_reg;
      end
      `SRCC_ADDR_SLEEPCFG: rdata_mux[`SRCC_NPERIPH-1:0] = sleep_sel_reg;
      `SRCC_ADDR_IRQ_STAT: rdata_mux[`SRCC_IRQ_W-1:0]   = irq_stat_reg;
      `SRCC_ADDR_IRQ_MASK: rdata_mux[`SRCC_IRQ_W-1:0]   = irq_mask_reg;
      `SRCC_ADDR_CLKGATE:  rdata_mux[0]                 = gate_en_reg;
      default:             rdata_mux = '0;
    endcase
  end

  // Read data registered, valid one cycle after strobe only
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= '0;
    else
      reg_rdata_out <= reg_rd_in ? rdata_mux : 32'h0000_0000;
  end

endmodule : srcc_top
